// ### hw/sfp_pkg.sv
// sfp_pkg: opcodes, status byte layout, frame counts and state type
// assumes a 100 MHz core clock and a serial link sampled by it
package sfp_pkg;

	// core clock period
	localparam int CLK_PERIOD_NS = 10;

	// command opcodes
	localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
	localparam logic [7:0] OP_ERASE_ALL_B = 8'hC7;
	localparam logic [7:0] OP_WRITE_EN = 8'h06;
	localparam logic [7:0] OP_WRITE_DIS = 8'h04;
	localparam logic [7:0] OP_PROTECT = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;

	// frame bit counts: opcode, opcode plus address, plus one data byte
	localparam logic [5:0] OPCODE_BITS = 6'h08;
	localparam logic [5:0] ADDR_END_BITS = 6'h20;
	localparam logic [5:0] DATA_END_BITS = 6'h28;
	localparam logic [5:0] WRSR_END_BITS = 6'h10; // status write: opcode plus its one data byte

	// status byte bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_WEL = 1;
	localparam int STAT_SEQ = 6;
	localparam int STAT_LOCK = 7;

	// reset values
	localparam logic RST_LOCK = 1'b0;
	localparam logic RST_WEL = 1'b0;

	// pin vector layout and its idle level (chip select high)
	localparam int PIN_SCK = 0;
	localparam int PIN_CS_N = 1;
	localparam int PIN_SI = 2;
	localparam int PIN_COUNT = 3;
	localparam logic [2:0] PIN_IDLE = 3'h2;

	// frame states, gray coded
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_SHIFT = 2'h1,
		ST_STATUS = 2'h3
	} sfp_state_type;

endpackage : sfp_pkg

// ### hw/sfp_pin_if.sv
// sfp_pin_if: synchronised serial pin events passed to the command logic
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface sfp_pin_if;
	logic sck_rise;
	logic sck_fall;
	logic cs_start;
	logic cs_end;
	logic si_bit;

	// synchroniser side
	modport src
	(
		output sck_rise, sck_fall, cs_start, cs_end, si_bit
	);

	// command logic side
	modport dst
	(
		input sck_rise, sck_fall, cs_start, cs_end, si_bit
	);
endinterface : sfp_pin_if

// ### hw/sfp_pin_sync.sv
// sfp_pin_sync: three-stage synchronisers and edge events for the link pins
// assumes the link clock is at most a quarter of the core clock rate
`timescale 1ns/1ps
module sfp_pin_sync
	import sfp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// raw pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	// events
	sfp_pin_if.src pins
);

	logic [PIN_COUNT-1:0] raw;
	logic [PIN_COUNT-1:0] s1_reg;
	logic [PIN_COUNT-1:0] s2_reg;
	logic [PIN_COUNT-1:0] s3_reg;
	logic [PIN_COUNT-1:0] stable_reg;
	logic [PIN_COUNT-1:0] rise_reg;
	logic [PIN_COUNT-1:0] fall_reg;

	assign raw = {si, cs_n, sck};

	// one chain per pin; a change counts only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_pin
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					s1_reg[gi] <= PIN_IDLE[gi];
					s2_reg[gi] <= PIN_IDLE[gi];
					s3_reg[gi] <= PIN_IDLE[gi];
					stable_reg[gi] <= PIN_IDLE[gi];
					rise_reg[gi] <= 1'b0;
					fall_reg[gi] <= 1'b0;
				end
				else
				begin
					s1_reg[gi] <= raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi])
						stable_reg[gi] <= s3_reg[gi];
					rise_reg[gi] <= (s2_reg[gi] == s3_reg[gi]) && s3_reg[gi] && !stable_reg[gi];
					fall_reg[gi] <= (s2_reg[gi] == s3_reg[gi]) && !s3_reg[gi] && stable_reg[gi];
				end
			end
		end
	endgenerate

	// events line up with the filtered level
	assign pins.sck_rise = rise_reg[PIN_SCK];
	assign pins.sck_fall = fall_reg[PIN_SCK];
	assign pins.cs_start = fall_reg[PIN_CS_N];
	assign pins.cs_end = rise_reg[PIN_CS_N];
	assign pins.si_bit = stable_reg[PIN_SI];

endmodule : sfp_pin_sync

// ### hw/sfp_flash_cmd.sv
// sfp_flash_cmd: serial flash command logic for whole-array erase,
// write-enable latch handling, sector protection and status read
// assumes the link pins are asynchronous and the link clock runs slowly enough
// to be sampled by the core clock; the erase engine acts on ERASE_START
//
// Operation
// - Opcodes 60h and C7h both mean whole-array erase, treated alike.
// - Whole-array erase starts only if the write-enable latch was already set.
// - Erase takes no address, ignores trailing bytes, starts at chip-select release.
// - Chip-select released before eight opcode bits means no erase.
// - Any protected sector blocks erase, clears the latch, returns to idle.
// - Busy reads back during erase; latch is cleared before erase ends.
// - Erase, protect, unprotect and status write need the latch set.
// - Opcode 06h sets the latch at chip-select release, trailing bytes ignored.
// - Incomplete enable or disable opcode leaves the latch unchanged.
// - Opcode 04h clears the latch at chip-select release, trailing bytes ignored.
// - The disable command also ends sequential byte program mode.
// - One protection bit per sector, all set after reset.
// - Clear bit allows program and erase, set bit blocks both.
// - 36h plus three address bytes protects the sector and clears the latch.
// - 39h plus three address bytes unprotects the sector and clears the latch.
// - Sector chosen from the full 24-bit address, any address within it.
// - Short address aborts, keeps protection, clears the latch.
// - With the lock flag set protect and unprotect are ignored, latch cleared.
// - Opcode 05h streams the status byte msb first, refreshed each byte.
// - Lock flag is status bit 7, writable, zero after reset.
`timescale 1ns/1ps
module sfp_flash_cmd
	import sfp_pkg::*;
#(
	parameter int NUM_SECTORS = 8,
	parameter int SECTOR_SHIFT = 16,
	parameter int ERASE_TIME_NS = 200000,
	parameter logic [7:0] WRSR_OPCODE = 8'h01
)
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// serial link pins
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	// sequential program mode
	input wire logic SEQ_MODE,
	output logic SEQ_EXIT,
	// status and array control
	output logic WRITE_ENABLE_LATCH,
	output logic PROTECT_REGS_LOCK_FLAG,
	output logic BUSY,
	output logic ERASE_START,
	output logic [NUM_SECTORS-1:0] SECTOR_PROTECT
);

	// erase time rounded up to whole core cycles, never below one
	localparam int ERASE_RAW = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = (ERASE_RAW < 1) ? 1 : ERASE_RAW;
	localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
	localparam int SIDX_W = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

	sfp_pin_if pins();

	sfp_state_type state_reg;
	logic [31:0] shift_reg;
	logic [5:0] bits_reg;
	logic [7:0] opcode_reg;
	logic [23:0] addr_reg;
	logic [7:0] data_reg;
	logic [2:0] out_idx_reg;
	logic [7:0] snap_reg;
	logic so_reg;
	logic so_oe_reg;
	logic wel_reg;
	logic wel_next;
	logic lock_reg;
	logic lock_next;
	logic [NUM_SECTORS-1:0] prot_reg;
	logic [NUM_SECTORS-1:0] prot_next;
	logic busy_reg;
	logic [CNT_W-1:0] erase_cnt_reg;
	logic erase_start_reg;
	logic start_erase;
	logic seq_exit_reg;
	logic seq_exit_next;
	logic frame_end;
	logic op_full;
	logic addr_full;
	logic data_full;
	logic is_erase;
	logic any_prot;
	logic [7:0] status_now;
	logic [31:0] shift_in;

	sfp_pin_sync u_sync
	(
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.sck(SCK),
		.cs_n(CS_N),
		.si(SI),
		.pins(pins)
	);

	// sector index from the whole address; addresses past the map fold to the top sector
	function automatic logic [SIDX_W-1:0] sector_of(input logic [23:0] addr);
		logic [23:0] idx;
		idx = addr >> SECTOR_SHIFT;
		if (idx >= 24'(NUM_SECTORS))
			sector_of = SIDX_W'(NUM_SECTORS - 1);
		else
			sector_of = idx[SIDX_W-1:0];
	endfunction : sector_of

	// frame decode terms
	assign frame_end = pins.cs_end && (state_reg == ST_SHIFT);
	assign op_full = bits_reg >= OPCODE_BITS;
	assign addr_full = bits_reg >= ADDR_END_BITS;
	assign data_full = bits_reg >= WRSR_END_BITS;
	assign is_erase = (opcode_reg == OP_ERASE_ALL_A) || (opcode_reg == OP_ERASE_ALL_B);
	assign any_prot = |prot_reg;
	assign shift_in = {shift_reg[30:0], pins.si_bit};

	// live status byte; unused bits read zero
	always_comb
	begin
		status_now = 8'h00;
		status_now[STAT_LOCK] = lock_reg;
		status_now[STAT_SEQ] = SEQ_MODE;
		status_now[STAT_WEL] = wel_reg;
		status_now[STAT_BUSY] = busy_reg;
	end

	// frame state: opcode decides between command capture and status streaming
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_reg <= ST_IDLE;
		else if (pins.cs_end)
			state_reg <= ST_IDLE;
		else if (pins.cs_start)
			state_reg <= ST_SHIFT;
		else if (state_reg == ST_SHIFT && pins.sck_rise && bits_reg == OPCODE_BITS - 6'h01
			&& shift_in[7:0] == OP_READ_STATUS)
			state_reg <= ST_STATUS;
	end

	// input shifter and saturating bit count; bytes past the data byte are ignored
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			shift_reg <= 32'h0000_0000;
			bits_reg <= 6'h00;
		end
		else if (pins.cs_start)
		begin
			shift_reg <= 32'h0000_0000;
			bits_reg <= 6'h00;
		end
		else if (state_reg == ST_SHIFT && pins.sck_rise && bits_reg < DATA_END_BITS)
		begin
			shift_reg <= shift_in;
			bits_reg <= bits_reg + 6'h01;
		end
	end

	// field capture at byte boundaries
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			opcode_reg <= 8'h00;
			addr_reg <= 24'h00_0000;
			data_reg <= 8'h00;
		end
		else if (pins.cs_start)
			opcode_reg <= 8'h00;
		else if (state_reg == ST_SHIFT && pins.sck_rise)
		begin
			if (bits_reg == OPCODE_BITS - 6'h01)
				opcode_reg <= shift_in[7:0];
			if (bits_reg == ADDR_END_BITS - 6'h01)
				addr_reg <= shift_in[23:0];
			if (bits_reg == WRSR_END_BITS - 6'h01)
				data_reg <= shift_in[7:0];
		end
	end

	// command execution at chip-select release; the engine busy blocks all but status read
	always_comb
	begin
		wel_next = wel_reg;
		lock_next = lock_reg;
		prot_next = prot_reg;
		start_erase = 1'b0;
		seq_exit_next = 1'b0;
		if (frame_end && op_full && !busy_reg)
		begin
			if (is_erase)
			begin
				if (any_prot)
					wel_next = 1'b0;
				else if (wel_reg)
				begin
					start_erase = 1'b1;
					wel_next = 1'b0;
				end
			end
			else if (opcode_reg == OP_WRITE_EN)
				wel_next = 1'b1;
			else if (opcode_reg == OP_WRITE_DIS)
			begin
				wel_next = 1'b0;
				seq_exit_next = SEQ_MODE;
			end
			else if (opcode_reg == OP_PROTECT || opcode_reg == OP_UNPROTECT)
			begin
				if (wel_reg)
				begin
					wel_next = 1'b0;
					if (addr_full && !lock_reg)
						prot_next[sector_of(addr_reg)] = (opcode_reg == OP_PROTECT);
				end
			end
			else if (opcode_reg == WRSR_OPCODE)
			begin
				if (wel_reg && data_full)
				begin
					lock_next = data_reg[STAT_LOCK];
					wel_next = 1'b0;
				end
			end
		end
	end

	// latch, lock flag and protection bits; every bit protected after reset
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			wel_reg <= RST_WEL;
			lock_reg <= RST_LOCK;
			prot_reg <= {NUM_SECTORS{1'b1}};
			seq_exit_reg <= 1'b0;
		end
		else
		begin
			wel_reg <= wel_next;
			lock_reg <= lock_next;
			prot_reg <= prot_next;
			seq_exit_reg <= seq_exit_next;
		end
	end

	// self-timed erase; busy holds for the full erase time
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			busy_reg <= 1'b0;
			erase_cnt_reg <= '0;
			erase_start_reg <= 1'b0;
		end
		else
		begin
			erase_start_reg <= start_erase;
			if (start_erase)
			begin
				busy_reg <= 1'b1;
				erase_cnt_reg <= CNT_W'(ERASE_CYCLES - 1);
			end
			else if (busy_reg)
			begin
				if (erase_cnt_reg == '0)
					busy_reg <= 1'b0;
				else
					erase_cnt_reg <= erase_cnt_reg - 1'b1;
			end
		end
	end

	// status stream on falling serial clock; snapshot per byte keeps a byte coherent
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
			out_idx_reg <= 3'h0;
			snap_reg <= 8'h00;
		end
		else if (state_reg != ST_STATUS || pins.cs_end)
		begin
			so_oe_reg <= 1'b0;
			out_idx_reg <= 3'h0;
		end
		else if (pins.sck_fall)
		begin
			so_oe_reg <= 1'b1;
			out_idx_reg <= out_idx_reg + 3'h1;
			if (out_idx_reg == 3'h0)
			begin
				snap_reg <= status_now;
				so_reg <= status_now[7];
			end
			else
				so_reg <= snap_reg[3'h7 - out_idx_reg];
		end
	end

	// outputs straight from flops
	assign SO = so_reg;
	assign SO_OE = so_oe_reg;
	assign SEQ_EXIT = seq_exit_reg;
	assign WRITE_ENABLE_LATCH = wel_reg;
	assign PROTECT_REGS_LOCK_FLAG = lock_reg;
	assign BUSY = busy_reg;
	assign ERASE_START = erase_start_reg;
	assign SECTOR_PROTECT = prot_reg;

	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);

	erase_opcode_a: assert property (frame_end && op_full && is_erase && wel_reg && !any_prot && !busy_reg
		|=> erase_start_reg && busy_reg)
		else $error("erase opcode did not start erase");

	erase_needs_wel_a: assert property ($rose(busy_reg) |-> $past(wel_reg, 2))
		else $error("erase started without write enable");

	erase_pulse_a: assert property (erase_start_reg |-> busy_reg ##1 !erase_start_reg)
		else $error("erase start not a single pulse");

	short_frame_a: assert property (frame_end && !op_full |=> $stable(wel_reg) && !start_erase)
		else $error("short opcode changed state");

	protected_erase_a: assert property (frame_end && op_full && is_erase && any_prot && !busy_reg
		|=> !wel_reg && !start_erase)
		else $error("protected erase not refused");

	busy_no_wel_a: assert property (busy_reg |-> !wel_reg)
		else $error("latch set while erasing");

	wren_a: assert property (frame_end && op_full && opcode_reg == OP_WRITE_EN && !busy_reg
		|=> wel_reg)
		else $error("write enable did not set latch");

	wrdi_a: assert property (frame_end && op_full && opcode_reg == OP_WRITE_DIS && !busy_reg && SEQ_MODE
		|=> !wel_reg && seq_exit_reg)
		else $error("write disable did not end sequential mode");

	prot_guard_a: assert property (prot_reg != $past(prot_reg) |-> $past(wel_reg) && !$past(lock_reg))
		else $error("protection changed without enable or while locked");

	addr_abort_a: assert property (frame_end && op_full && !addr_full && wel_reg && !busy_reg
		&& (opcode_reg == OP_PROTECT || opcode_reg == OP_UNPROTECT) |=> $stable(prot_reg) && !wel_reg)
		else $error("short address not aborted");

	status_drive_a: assert property (so_oe_reg |-> state_reg == ST_STATUS || $past(pins.cs_end))
		else $error("output driven outside status read");

	erase_cov: cover property (start_erase);
	protect_cov: cover property (frame_end && addr_full && wel_reg && opcode_reg == OP_UNPROTECT);
	status_cov: cover property (so_oe_reg && out_idx_reg == 3'h0 ##1 so_oe_reg);
	locked_cov: cover property (frame_end && addr_full && wel_reg && lock_reg);

endmodule : sfp_flash_cmd

// ### verif/sfp_host_model.sv
// sfp_host_model: serial host that frames commands on the link pins
// assumes the 100 MHz core clock paces it; one serial clock period is 8 core cycles
`timescale 1ns/1ps
module sfp_host_model
(
	// pacing clock
	input wire logic clk,
	// link pins
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// one frame, d left aligned; sck stands low outside frames
	// so is caught just before each fall of the second byte, long after it settled
	task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			si <= d[39-i];
			repeat (3) @(posedge clk);
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			if (i >= 8 && i < 16)
				rd[15-i] = so;
			sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si; // released line never shows the last bit
		repeat (12) @(posedge clk);
	endtask : xfer
endmodule : sfp_host_model

// ### verif/serial_flash_erase_protect_cmds_tb.sv
// serial_flash_erase_protect_cmds_tb: self-checking bench for the command logic
// assumes the host model drives the link; erase time shortened for simulation
`timescale 1ns/1ps
module serial_flash_erase_protect_cmds_tb;
	import sfp_pkg::*;
	localparam logic [7:0] WRSR_OP = 8'h01;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic seq_mode = 1'b0;
	logic sck, cs_n, si, so, so_oe, seq_exit, write_enable_latch, lock, busy, erase_start;
	logic [7:0] prot;
	logic [7:0] exp_prot = 8'hFF;
	logic exp_wel = 1'b0;
	logic exp_lock = 1'b0;
	logic [7:0] rd;
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 98211;
	int n_erase = 0;
	int n_exit = 0;
	int n_oe = 0;

	always #5 clk = ~clk;

	sfp_flash_cmd #(.NUM_SECTORS(8), .SECTOR_SHIFT(16), .ERASE_TIME_NS(2000), .WRSR_OPCODE(WRSR_OP)) i_dut
	(
		.CORE_CLK(clk), .ARST_N(arst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
		.SEQ_MODE(seq_mode), .SEQ_EXIT(seq_exit), .WRITE_ENABLE_LATCH(write_enable_latch),
		.PROTECT_REGS_LOCK_FLAG(lock), .BUSY(busy), .ERASE_START(erase_start), .SECTOR_PROTECT(prot)
	);

	sfp_host_model i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

	// erase and exit pulse counters, both pulses one cycle long, plus an output-enable cycle count
	always @(posedge clk)
	begin
		if (erase_start === 1'b1)
			n_erase++;
		if (seq_exit === 1'b1)
			n_exit++;
		if (so_oe === 1'b1)
			n_oe++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_state();
		chk({write_enable_latch, lock, prot}, {exp_wel, exp_lock, exp_prot});
	endtask : chk_state

	task automatic cmd(input logic [39:0] d, input int n);
		i_host.xfer(d, n, rd);
	endtask : cmd

	task automatic wren();
		cmd({OP_WRITE_EN, 32'h0}, 8);
		exp_wel = 1'b1;
	endtask : wren

	// expected status byte from the expected state
	function automatic logic [7:0] stat(input logic b);
		return {exp_lock, seq_mode, 4'h0, exp_wel, b};
	endfunction : stat

	// random address inside sector s, upper bits kept clear
	function automatic logic [23:0] sec_addr(input int s);
		return {5'h00, 3'(s), 16'($random(seed))};
	endfunction : sec_addr

	task automatic end_sim();
		$display("errors=%0d checked=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// watchdog, well beyond the expected run of about 7k cycles
	initial
	begin
		#300000;
		num_errors++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk_state();
		// cut-short enable and disable opcodes leave the latch alone
		cmd({OP_WRITE_EN, 32'h0}, 1 + ($unsigned($random(seed)) % 7));
		chk_state();
		cmd({OP_WRITE_EN, 32'hA5000000}, 16);
		exp_wel = 1'b1;
		chk_state();
		cmd({OP_WRITE_DIS, 32'h0}, 1 + ($unsigned($random(seed)) % 7));
		chk_state();
		seq_mode <= 1'b1;
		cmd({OP_READ_STATUS, 32'h0}, 16);
		chk(rd, stat(1'b0));
		// output enabled from the first fall after the opcode until chip-select release
		chk(n_oe, 8 * (16 - 8) + 4);
		chk(so_oe, 1'b0);
		cmd({OP_WRITE_DIS, 32'h5A000000}, 16);
		exp_wel = 1'b0;
		chk_state();
		chk(n_exit, 1);
		seq_mode <= 1'b0;
		// erase refused without latch, then with all sectors protected
		cmd({OP_ERASE_ALL_A, 32'h0}, 8);
		chk(n_erase, 0);
		wren();
		cmd({OP_ERASE_ALL_B, 32'h0}, 8);
		exp_wel = 1'b0;
		chk_state();
		chk(n_erase, 0);
		cmd({OP_UNPROTECT, sec_addr(0), 8'h00}, 32);
		chk_state();
		wren();
		cmd({OP_UNPROTECT, sec_addr(3), 8'h00}, 16 + 8 * ($unsigned($random(seed)) % 2));
		exp_wel = 1'b0;
		chk_state();
		for (int s = 7; s >= 0; s--)
		begin
			wren();
			cmd({OP_UNPROTECT, sec_addr(s), 8'hFF}, 40);
			exp_prot[s] = 1'b0;
			exp_wel = 1'b0;
			chk_state();
		end
		// both erase opcodes, each first cut short
		for (int k = 0; k < 2; k++)
		begin
			wren();
			cmd({k ? OP_ERASE_ALL_B : OP_ERASE_ALL_A, 32'h0}, 7);
			chk(n_erase, k);
			cmd({k ? OP_ERASE_ALL_B : OP_ERASE_ALL_A, 32'h3C000000}, 16);
			exp_wel = 1'b0;
			chk(n_erase, k + 1);
			chk(busy, 1'b1);
			cmd({OP_READ_STATUS, 32'h0}, 16);
			chk(rd, stat(1'b1));
			for (int p = 0; p < 8 && rd[0] !== 1'b0; p++)
				cmd({OP_READ_STATUS, 32'h0}, 16);
			chk(rd, stat(1'b0));
			chk_state();
		end
		// one protected sector blocks erase
		wren();
		cmd({OP_PROTECT, sec_addr(5), 8'h00}, 40);
		exp_prot[5] = 1'b1;
		exp_wel = 1'b0;
		chk_state();
		wren();
		cmd({OP_ERASE_ALL_A, 32'h0}, 8);
		exp_wel = 1'b0;
		chk(n_erase, 2);
		chk_state();
		// lock flag blocks protection changes
		wren();
		cmd({WRSR_OP, 8'h80, 24'h0}, 16);
		exp_lock = 1'b1;
		exp_wel = 1'b0;
		chk_state();
		wren();
		cmd({OP_UNPROTECT, sec_addr(5), 8'h00}, 32);
		exp_wel = 1'b0;
		chk_state();
		// reset in mid-run restores protection and unlocks
		arst_n <= 1'b0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		exp_prot = 8'hFF;
		exp_lock = 1'b0;
		chk_state();
		end_sim();
	end
endmodule : serial_flash_erase_protect_cmds_tb
